// ### verilog/pinstrap_config_latch.sv
// Top of the strap configuration latch with its Avalon-MM register slave.
// Assumes strap codes and samples are settled and synchronous to MCLK at rail power-up.
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module pinstrap_config_latch
   import strap_cfg_pkg::*;
(
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [ADDR_W-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire strap_meas_t RATE_MODE_STRAP,
   input wire strap_meas_t SHOOT_REDUCTION_STRAP,
   input wire strap_meas_t STARTUP_VOLTAGE_STRAP,
   input wire strap_meas_t BUS_ID_RAMP_STRAP,
   input wire strap_meas_t FREQ_CURRENT_STRAP,
   input wire strap_meas_t LIMIT_RAMP_STRAP,
   input wire logic BIAS_RAIL_3V,
   input wire logic CONFIG_SOURCE_SELECT,
   input wire settings_t NVM_CFG,
   output settings_t CFG_OUT,
   output logic CFG_CAPTURED
);

   // ******************************************************
   // Voltage level decoding
   // ******************************************************
   logic [3:0] mode_lvl;
   logic [2:0] undershoot_lvl;
   logic [3:0] boot_hi_lvl;
   logic [3:0] addr_lvl;
   logic [7:0] current_code_lvl;
   logic [1:0] ramp_lvl;

   level_quantizer #(.IN_W(RATIO_W), .OUT_W(4)) u_mode_q (
      .ratio(RATE_MODE_STRAP.v_ratio),
      .level(mode_lvl)
   );

   level_quantizer #(.IN_W(RATIO_W), .OUT_W(3)) u_undershoot_q (
      .ratio(SHOOT_REDUCTION_STRAP.v_ratio),
      .level(undershoot_lvl)
   );

   level_quantizer #(.IN_W(RATIO_W), .OUT_W(4)) u_boot_q (
      .ratio(STARTUP_VOLTAGE_STRAP.v_ratio),
      .level(boot_hi_lvl)
   );

   level_quantizer #(.IN_W(RATIO_W), .OUT_W(4)) u_addr_q (
      .ratio(BUS_ID_RAMP_STRAP.v_ratio),
      .level(addr_lvl)
   );

   level_quantizer #(.IN_W(RATIO_W), .OUT_W(8)) u_current_q (
      .ratio(FREQ_CURRENT_STRAP.v_ratio),
      .level(current_code_lvl)
   );

   level_quantizer #(.IN_W(RATIO_W), .OUT_W(2)) u_ramp_q (
      .ratio(LIMIT_RAMP_STRAP.v_ratio),
      .level(ramp_lvl)
   );

   // ******************************************************
   // Strap decode and source selection
   // ******************************************************
   settings_t strap_cfg;
   settings_t src_cfg;

   assign strap_cfg.slew_rate = RATE_MODE_STRAP.r_code;
   assign strap_cfg.dac_vr120 = mode_lvl[3];
   assign strap_cfg.pair_interleave = mode_lvl[2];
   assign strap_cfg.phase_shed_en = mode_lvl[1];
   assign strap_cfg.zero_loadline = mode_lvl[0];
   assign strap_cfg.overshoot_reduction = SHOOT_REDUCTION_STRAP.r_code;
   assign strap_cfg.undershoot_reduction = undershoot_lvl;
   assign strap_cfg.voltage_code = {boot_hi_lvl, STARTUP_VOLTAGE_STRAP.r_code,
                                    BUS_ID_RAMP_STRAP.r_code[0]};
   assign strap_cfg.soft_start_rise_rate = BUS_ID_RAMP_STRAP.r_code[2:1];
   assign strap_cfg.bus_address = addr_lvl;
   assign strap_cfg.switch_freq = FREQ_CURRENT_STRAP.r_code;
   assign strap_cfg.max_load_current_code = current_code_lvl;
   // Resistor gives the coarse step, voltage half-scale the fine step
   assign strap_cfg.per_phase_current_limit = {LIMIT_RAMP_STRAP.r_code, ramp_lvl[1]};
   assign strap_cfg.ramp_level = ramp_lvl;

   // The address has no NVM copy, so it always comes from its strap
   always_comb
   begin
      src_cfg = CONFIG_SOURCE_SELECT ? strap_cfg : NVM_CFG;
      src_cfg.bus_address = strap_cfg.bus_address;
   end

   // ******************************************************
   // Rail power-up capture
   // ******************************************************
   logic rail_q;
   logic rail_rise;
   logic captured_q;
   logic src_strap_q;

   // Rail low out of reset, so a rail already up captures at the first edge
   assign rail_rise = BIAS_RAIL_3V & ~rail_q;

   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rail_q <= 1'b0;
         captured_q <= 1'b0;
         src_strap_q <= 1'b0;
      end
      else
      begin
         rail_q <= BIAS_RAIL_3V;
         captured_q <= captured_q | rail_rise;
         if (rail_rise)
            src_strap_q <= CONFIG_SOURCE_SELECT;
      end
   end

   // ******************************************************
   // Avalon-MM slave: one wait state, then the answer
   // ******************************************************
   logic req;
   logic accept;
   logic wait_q;
   logic wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] be_mask;
   logic sel_a;
   logic sel_b;
   logic sel_c;
   logic sel_stat;
   logic wr_a;
   logic wr_b;
   logic wr_c;

   assign req = AVS_READ | AVS_WRITE;
   assign accept = req & ~wait_q;
   assign wait_d = accept | ~req;
   assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                     {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign sel_stat = AVS_ADDRESS == STATUS_OFS;
   assign sel_a = AVS_ADDRESS == CFG_A_OFS;
   assign sel_b = AVS_ADDRESS == CFG_B_OFS;
   assign sel_c = AVS_ADDRESS == CFG_C_OFS;
   assign wr_a = accept & AVS_WRITE & sel_a;
   assign wr_b = accept & AVS_WRITE & sel_b;
   assign wr_c = accept & AVS_WRITE & sel_c;

   // ******************************************************
   // Held settings words
   // ******************************************************
   logic [CFG_A_W-1:0] cap_a;
   logic [CFG_B_W-1:0] cap_b;
   logic [CFG_C_W-1:0] cap_c;
   logic [CFG_A_W-1:0] cfg_a;
   logic [CFG_B_W-1:0] cfg_b;
   logic [CFG_C_W-1:0] cfg_c;
   logic [3:0] addr_q;

   assign cap_a = {src_cfg.undershoot_reduction, 1'b0, src_cfg.overshoot_reduction,
                   src_cfg.dac_vr120, src_cfg.pair_interleave, src_cfg.phase_shed_en,
                   src_cfg.zero_loadline, 1'b0, src_cfg.slew_rate};
   assign cap_b = {src_cfg.switch_freq, 2'b00, src_cfg.soft_start_rise_rate,
                   src_cfg.voltage_code};
   assign cap_c = {src_cfg.ramp_level, src_cfg.per_phase_current_limit,
                   src_cfg.max_load_current_code};

   // Software may retune settings later; straps alone never touch them again
   setting_latch #(.W(CFG_A_W), .RST_VAL(CFG_A_RST)) u_cfg_a (
      .clk(MCLK),
      .rst(SYS_RST),
      .capture(rail_rise),
      .cap_val(cap_a),
      .wr_en(wr_a),
      .wr_mask(be_mask[CFG_A_W-1:0]),
      .wr_val(AVS_WRITEDATA[CFG_A_W-1:0]),
      .q(cfg_a)
   );

   setting_latch #(.W(CFG_B_W), .RST_VAL(CFG_B_RST)) u_cfg_b (
      .clk(MCLK),
      .rst(SYS_RST),
      .capture(rail_rise),
      .cap_val(cap_b),
      .wr_en(wr_b),
      .wr_mask(be_mask[CFG_B_W-1:0]),
      .wr_val(AVS_WRITEDATA[CFG_B_W-1:0]),
      .q(cfg_b)
   );

   setting_latch #(.W(CFG_C_W), .RST_VAL(CFG_C_RST)) u_cfg_c (
      .clk(MCLK),
      .rst(SYS_RST),
      .capture(rail_rise),
      .cap_val(cap_c),
      .wr_en(wr_c),
      .wr_mask(be_mask[CFG_C_W-1:0]),
      .wr_val(AVS_WRITEDATA[CFG_C_W-1:0]),
      .q(cfg_c)
   );

   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
         addr_q <= ADDR_RST;
      else if (rail_rise)
         addr_q <= src_cfg.bus_address;
   end

   // ******************************************************
   // Read mux and bus registers
   // ******************************************************
   logic [31:0] stat_word;

   assign stat_word = {29'h0000000, BIAS_RAIL_3V, src_strap_q, captured_q};
   assign rdata_d = sel_stat ? stat_word :
                    sel_a ? {17'h00000, cfg_a} :
                    sel_b ? {17'h00000, cfg_b} :
                    sel_c ? {12'h000, addr_q, 2'b00, cfg_c} : 32'h00000000;

   // Data loads in the wait cycle so it stands at the accepting edge
   always_ff @(posedge MCLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         wait_q <= wait_d;
         if (req & wait_q & AVS_READ)
            rdata_q <= rdata_d;
      end
   end

   assign AVS_WAITREQUEST = wait_q;
   assign AVS_READDATA = rdata_q;
   assign CFG_CAPTURED = captured_q;

   assign CFG_OUT.slew_rate = cfg_a[A_SLEW_LSB +: 3];
   assign CFG_OUT.dac_vr120 = cfg_a[A_MODE_LSB + 3];
   assign CFG_OUT.pair_interleave = cfg_a[A_MODE_LSB + 2];
   assign CFG_OUT.phase_shed_en = cfg_a[A_MODE_LSB + 1];
   assign CFG_OUT.zero_loadline = cfg_a[A_MODE_LSB];
   assign CFG_OUT.overshoot_reduction = cfg_a[A_OVERSHOOT_LSB +: 3];
   assign CFG_OUT.undershoot_reduction = cfg_a[A_UNDERSHOOT_LSB +: 3];
   assign CFG_OUT.voltage_code = cfg_b[B_BOOT_LSB +: 8];
   assign CFG_OUT.soft_start_rise_rate = cfg_b[B_RISE_LSB +: 2];
   assign CFG_OUT.switch_freq = cfg_b[B_FREQ_LSB +: 3];
   assign CFG_OUT.max_load_current_code = cfg_c[C_CURRENT_LSB +: 8];
   assign CFG_OUT.per_phase_current_limit = cfg_c[C_LIMIT_LSB +: 4];
   assign CFG_OUT.ramp_level = cfg_c[C_RAMP_LSB +: 2];
   assign CFG_OUT.bus_address = addr_q;

   // ******************************************************
   // Assertions
   // ******************************************************
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);

   logic strap_cap;
   assign strap_cap = rail_rise & CONFIG_SOURCE_SELECT;

   sequence s_req_waits;
      req && AVS_WAITREQUEST;
   endsequence

   sequence s_answer;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence

   property p_slew;
      strap_cap |=> CFG_OUT.slew_rate == $past(RATE_MODE_STRAP.r_code);
   endproperty
   a_slew: assert property (p_slew) else $error("slew rate not captured");

   property p_dac;
      strap_cap |=> CFG_OUT.dac_vr120 == ($past(RATE_MODE_STRAP.v_ratio) >= 10'h200);
   endproperty
   a_dac: assert property (p_dac) else $error("DAC mode bit wrong");

   property p_modes;
      strap_cap |=> {CFG_OUT.pair_interleave, CFG_OUT.phase_shed_en,
                     CFG_OUT.zero_loadline} == $past(mode_lvl[2:0]);
   endproperty
   a_modes: assert property (p_modes) else $error("mode bits wrong");

   property p_captured;
      rail_rise |=> CFG_CAPTURED ##1 CFG_CAPTURED;
   endproperty
   a_captured: assert property (p_captured) else $error("capture flag missing");

   property p_shoot;
      strap_cap |=> CFG_OUT.overshoot_reduction == $past(SHOOT_REDUCTION_STRAP.r_code)
         && (($past(SHOOT_REDUCTION_STRAP.v_ratio) == 10'h000)
             -> CFG_OUT.undershoot_reduction == 3'h0);
   endproperty
   a_shoot: assert property (p_shoot) else $error("shoot reduction wrong");

   property p_boot;
      strap_cap |=> CFG_OUT.voltage_code[3:1] == $past(STARTUP_VOLTAGE_STRAP.r_code)
         && CFG_OUT.voltage_code[0] == $past(BUS_ID_RAMP_STRAP.r_code[0])
         && CFG_OUT.soft_start_rise_rate == $past(BUS_ID_RAMP_STRAP.r_code[2:1]);
   endproperty
   a_boot: assert property (p_boot) else $error("boot code wrong");

   property p_addr;
      rail_rise |=> CFG_OUT.bus_address == $past(addr_lvl);
   endproperty
   a_addr: assert property (p_addr) else $error("address not from strap");

   property p_max_load_current_code;
      strap_cap |=> (18'(CFG_OUT.max_load_current_code) * 18'd1023
                     <= 18'($past(FREQ_CURRENT_STRAP.v_ratio)) * 18'd255 + 18'd511)
         && (18'(CFG_OUT.max_load_current_code) * 18'd1023 + 18'd1023
             > 18'($past(FREQ_CURRENT_STRAP.v_ratio)) * 18'd255 + 18'd511);
   endproperty
   a_max_load_current_code: assert property (p_max_load_current_code) else $error("current code off");

   property p_limit;
      strap_cap |=> CFG_OUT.switch_freq == $past(FREQ_CURRENT_STRAP.r_code)
         && CFG_OUT.per_phase_current_limit[3:1] == $past(LIMIT_RAMP_STRAP.r_code)
         && CFG_OUT.ramp_level == $past(ramp_lvl);
   endproperty
   a_limit: assert property (p_limit) else $error("limit or ramp wrong");

   property p_hold;
      !rail_rise && !accept |=> $stable(CFG_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("settings moved");

   property p_nvm;
      rail_rise && !CONFIG_SOURCE_SELECT |=> CFG_OUT.switch_freq == $past(NVM_CFG.switch_freq)
         && CFG_OUT.voltage_code == $past(NVM_CFG.voltage_code);
   endproperty
   a_nvm: assert property (p_nvm) else $error("NVM source ignored");

   property p_bus;
      s_req_waits |=> s_answer;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer not after one wait");

endmodule : pinstrap_config_latch

// ### verilog/strap_cfg_pkg.sv
// Constants, field layouts and carrier types for the strap configuration latch.
// Assumes strap measurements arrive already digitised and synchronous to MCLK.
//
// Operation
// - Rate strap resistor code picks one of eight output slew rates.
// - Mode bit 7 from rate strap voltage: 1 older DAC encoding, 0 newer.
// - Mode bit 6: 1 pairs phases 1/3 and 2/4, 0 interleaves all four.
// - Mode bit 5: 1 enables dynamic phase add and drop, 0 disables it.
// - Mode bit 4: 1 selects zero load-line, 0 non-zero load-line.
// - All decoded settings are captured when the 3.3 V bias rail comes up.
// - Shoot strap resistor picks one of seven overshoot thresholds or off.
// - Shoot strap voltage picks one of seven undershoot levels or off.
// - Startup strap resistor gives boot code bits 3..1, its voltage bits 7..4.
// - Bus-id strap resistor: bits 2..1 soft-start rate, bit 0 boot code LSB.
// - Bus-id strap voltage sets four bits of the bus target address.
// - Frequency strap resistor selects the switching frequency setting.
// - Frequency strap voltage gives an 8-bit current code, ratio times 255.
// - Limit strap resistor and voltage jointly pick one of sixteen limits.
// - Limit strap voltage also picks one of four ramp levels.
// - Straps used only with low source resistance; otherwise NVM, except address.

package strap_cfg_pkg;

   // ******************************************************
   // Measurement and settings carriers
   // ******************************************************
   localparam int RATIO_W = 10;
   localparam int RCODE_W = 3;

   typedef struct packed {
      logic [RCODE_W-1:0] r_code;
      logic [RATIO_W-1:0] v_ratio;
   } strap_meas_t;

   typedef struct packed {
      logic [2:0] slew_rate;
      logic dac_vr120;
      logic pair_interleave;
      logic phase_shed_en;
      logic zero_loadline;
      logic [2:0] overshoot_reduction;
      logic [2:0] undershoot_reduction;
      logic [7:0] voltage_code;
      logic [1:0] soft_start_rise_rate;
      logic [3:0] bus_address;
      logic [2:0] switch_freq;
      logic [7:0] max_load_current_code;
      logic [3:0] per_phase_current_limit;
      logic [1:0] ramp_level;
   } settings_t;

   localparam logic [2:0] REDUCTION_OFF = 3'h7;

   // ******************************************************
   // Register map, byte offsets
   // ******************************************************
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h00;
   localparam logic [ADDR_W-1:0] CFG_A_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] CFG_B_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] CFG_C_OFS = 5'h0C;

   localparam int STAT_CAPTURED = 0;
   localparam int STAT_STRAP_SRC = 1;
   localparam int STAT_RAIL = 2;

   localparam int CFG_A_W = 15;
   localparam int A_SLEW_LSB = 0;
   localparam int A_MODE_LSB = 4;
   localparam int A_OVERSHOOT_LSB = 8;
   localparam int A_UNDERSHOOT_LSB = 12;

   localparam int CFG_B_W = 15;
   localparam int B_BOOT_LSB = 0;
   localparam int B_RISE_LSB = 8;
   localparam int B_FREQ_LSB = 12;

   localparam int CFG_C_W = 14;
   localparam int C_CURRENT_LSB = 0;
   localparam int C_LIMIT_LSB = 8;
   localparam int C_RAMP_LSB = 12;
   localparam int C_ADDR_LSB = 16;

   localparam logic [CFG_A_W-1:0] CFG_A_RST = 15'h0000;
   localparam logic [CFG_B_W-1:0] CFG_B_RST = 15'h0000;
   localparam logic [CFG_C_W-1:0] CFG_C_RST = 14'h0000;
   localparam logic [3:0] ADDR_RST = 4'h0;

endpackage : strap_cfg_pkg

// ### verilog/level_quantizer.sv
// Maps a ratiometric strap voltage sample onto evenly spaced levels.
// Assumes the sample is the pin voltage over the reference, full scale all ones.
`timescale 1ns/1ps

module level_quantizer #(
   parameter int IN_W = 10,
   parameter int OUT_W = 3
) (
   input wire logic [IN_W-1:0] ratio,
   output logic [OUT_W-1:0] level
);

   localparam int PW = IN_W + OUT_W + 1;
   localparam logic [PW-1:0] FULL = PW'((1 << IN_W) - 1);
   localparam logic [PW-1:0] MAXL = PW'((1 << OUT_W) - 1);
   localparam logic [PW-1:0] HALF = PW'(((1 << IN_W) - 1) / 2);

   generate
      if (OUT_W < 1 || OUT_W > IN_W)
      begin : g_bad_width
         $error("level_quantizer: OUT_W must lie between 1 and IN_W");
      end
   endgenerate

   logic [PW-1:0] scaled;
   logic [PW-1:0] quot;

   // Rounded level = ratio * (2^OUT_W - 1) / full scale
   assign scaled = PW'(ratio) * MAXL + HALF;
   assign quot = scaled / FULL;
   assign level = quot[OUT_W-1:0];

endmodule : level_quantizer

// ### verilog/setting_latch.sv
// One settings word: loaded at capture, or byte-merged by a bus write.
// Assumes capture and write strobes are single-cycle and synchronous to clk.
`timescale 1ns/1ps

module setting_latch #(
   parameter int W = 15,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic capture,
   input wire logic [W-1:0] cap_val,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_mask,
   input wire logic [W-1:0] wr_val,
   output logic [W-1:0] q
);

   generate
      if (W < 1 || W > 32)
      begin : g_bad_width
         $error("setting_latch: W must lie between 1 and 32");
      end
   endgenerate

   logic [W-1:0] q_q;
   logic [W-1:0] q_d;
   logic [W-1:0] merged;

   // Capture beats a coincident write: power-up values must not be lost
   assign merged = (q_q & ~wr_mask) | (wr_val & wr_mask);
   assign q_d = capture ? cap_val : (wr_en ? merged : q_q);
   assign q = q_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q_q <= RST_VAL;
      else
         q_q <= q_d;
   end

endmodule : setting_latch

// ### verification/strap_network.sv
// Partner model: one resistor to ground and one divider to the reference on each strap pin.
// Assumes the bench picks the resistor bin and divider ratio; the measurement is ideal.
`timescale 1ns/1ps

module strap_network
   import strap_cfg_pkg::*;
(
   input wire logic [5:0][2:0] r_bin,
   input wire logic [5:0][9:0] v_div,
   input wire logic [7:0] skip_kohm,
   output strap_meas_t [5:0] pins,
   output logic src_strap
);
   // ******************************************************
   // Pin network
   // ******************************************************
   // Pins are static straps, so the measured value simply follows the chosen parts
   genvar k;
   for (k = 0; k < 6; k++)
   begin : g_pin
      assign pins[k] = '{r_code: r_bin[k], v_ratio: v_div[k]};
   end
   // Anything above the low band reads as the NVM choice; the mid band is not a legal part
   assign src_strap = (skip_kohm <= 8'h14);
endmodule : strap_network

// ### verification/tb.sv
// Self-checking bench for the strap configuration latch, with a queue-free reference model.
// Assumes the design answers each bus access after one wait cycle and captures on rail rise.
`timescale 1ns/1ps

module tb;
   import strap_cfg_pkg::*;
   logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, rail, src, captured;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic [5:0][2:0] r_bin, rr;
   logic [5:0][9:0] v_div, vv;
   logic [7:0] skip_kohm;
   strap_meas_t [5:0] pins;
   settings_t nvm_cfg, cfg_out, exp;
   int n_mismatch, compares, cycles, i, k;
   logic [31:0] seed, d;

   strap_network strap_network_inst (.r_bin(r_bin), .v_div(v_div), .skip_kohm(skip_kohm),
      .pins(pins), .src_strap(src));
   pinstrap_config_latch pinstrap_config_latch_inst (.MCLK(mclk), .SYS_RST(sys_rst),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .RATE_MODE_STRAP(pins[0]), .SHOOT_REDUCTION_STRAP(pins[1]),
      .STARTUP_VOLTAGE_STRAP(pins[2]), .BUS_ID_RAMP_STRAP(pins[3]),
      .FREQ_CURRENT_STRAP(pins[4]), .LIMIT_RAMP_STRAP(pins[5]), .BIAS_RAIL_3V(rail),
      .CONFIG_SOURCE_SELECT(src), .NVM_CFG(nvm_cfg), .CFG_OUT(cfg_out),
      .CFG_CAPTURED(captured));

   // ******************************************************
   // Clock, timeout and reporting
   // ******************************************************
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Whole run is well under 3000 cycles; the ceiling leaves ample margin
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         $display("[FAIL] %0t timeout", $time);
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [63:0] got, input logic [63:0] want, input string what);
      compares++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, want);
      end
   endtask : chk

   // ******************************************************
   // Reference model
   // ******************************************************
   function automatic int lvl(input logic [9:0] v, input int n);
      return (int'(v) * ((1 << n) - 1) + 511) / 1023;
   endfunction : lvl

   function automatic settings_t model(input logic s_src, input settings_t nvm);
      settings_t s;
      s.slew_rate = rr[0];
      {s.dac_vr120, s.pair_interleave, s.phase_shed_en, s.zero_loadline} = 4'(lvl(vv[0], 4));
      s.overshoot_reduction = rr[1];
      s.undershoot_reduction = 3'(lvl(vv[1], 3));
      s.voltage_code = {4'(lvl(vv[2], 4)), rr[2], rr[3][0]};
      s.soft_start_rise_rate = rr[3][2:1];
      s.bus_address = 4'(lvl(vv[3], 4));
      s.switch_freq = rr[4];
      s.max_load_current_code = 8'(lvl(vv[4], 8));
      s.ramp_level = 2'(lvl(vv[5], 2));
      s.per_phase_current_limit = {rr[5], s.ramp_level[1]};
      if (!s_src)
      begin
         nvm.bus_address = s.bus_address;
         s = nvm;
      end
      return s;
   endfunction : model

   // ******************************************************
   // Bus and capture tasks
   // ******************************************************
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge mclk);
         n++;
      end
      chk(n, 1, "bus wait");
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic check_regs(input logic [2:0] status);
      bus(0, STATUS_OFS, 0, 0);
      chk(rd, status, "status");
      bus(0, CFG_A_OFS, 0, 0);
      chk(rd, {exp.undershoot_reduction, 1'b0, exp.overshoot_reduction, exp.dac_vr120,
         exp.pair_interleave, exp.phase_shed_en, exp.zero_loadline, 1'b0, exp.slew_rate}, "a");
      bus(0, CFG_B_OFS, 0, 0);
      chk(rd, {exp.switch_freq, 2'b0, exp.soft_start_rise_rate, exp.voltage_code}, "b");
      bus(0, CFG_C_OFS, 0, 0);
      chk(rd, {exp.bus_address, 2'b0, exp.ramp_level, exp.per_phase_current_limit,
         exp.max_load_current_code}, "c");
      chk(cfg_out, exp, "settings");
   endtask : check_regs

   // Rail is seen low for one edge, then the rising edge captures
   task automatic power_cycle();
      rail <= 1'b0;
      r_bin <= rr;
      v_div <= vv;
      @(posedge mclk);
      rail <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : power_cycle

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial
   begin
      seed = 32'h954E7827;
      {sys_rst, avs_read, avs_write, rail} = 4'h8;
      {avs_address, avs_writedata, avs_byteenable} = '0;
      {r_bin, v_div, rr, vv, nvm_cfg} = '0;
      skip_kohm = 8'h0A;
      repeat (2) @(posedge mclk);
      chk({cfg_out, captured}, 0, "reset");
      sys_rst <= 1'b0;
      @(posedge mclk);
      for (i = 0; i < 26; i++)
      begin
         for (k = 0; k < 6; k++)
            {rr[k], vv[k]} = 13'($random(seed));
         if (i < 16)
            {rr[1], vv[0]} = {3'(i), 10'(i * 1023 / 15)};
         if (i == 16 || i == 17)
            vv = (i == 16) ? '0 : '1;
         skip_kohm <= (i % 3 == 0) ? 8'h64 : 8'h0A;
         nvm_cfg <= settings_t'({$random(seed), $random(seed)});
         power_cycle();
         exp = model(i % 3 != 0, nvm_cfg);
         check_regs({1'b1, i % 3 != 0, 1'b1});
      end
      $display("test capture done");
      for (k = 0; k < 6; k++)
         {rr[k], vv[k]} = 13'($random(seed));
      r_bin <= rr;
      v_div <= vv;
      repeat (5) @(posedge mclk);
      check_regs(3'h7);
      $display("test hold done");
      // Spare bits of a settings word are storable, so keep them clear in the stimulus
      d = $random(seed) & 32'hFFFFF7F7;
      bus(1, CFG_A_OFS, d, 4'hF);
      exp.slew_rate = d[2:0];
      {exp.dac_vr120, exp.pair_interleave, exp.phase_shed_en, exp.zero_loadline} = d[7:4];
      {exp.undershoot_reduction, exp.overshoot_reduction} = {d[14:12], d[10:8]};
      bus(1, CFG_B_OFS, ~d & 32'hFFFFF3FF, 4'h2);
      {exp.switch_freq, exp.soft_start_rise_rate} = {~d[14:12], ~d[9:8]};
      bus(1, CFG_C_OFS, d, 4'hF);
      {exp.ramp_level, exp.per_phase_current_limit} = d[13:8];
      exp.max_load_current_code = d[7:0];
      bus(1, STATUS_OFS, 0, 4'hF);
      bus(1, 5'h10, d, 4'hF);
      bus(0, 5'h10, 0, 0);
      chk(rd, 0, "unmapped");
      check_regs(3'h7);
      $display("test writes done");
      power_cycle();
      exp = model(1, nvm_cfg);
      check_regs(3'h7);
      $display("test recapture done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      chk({cfg_out, captured}, 0, "mid reset");
      $display("test reset done");
      finish_test();
   end
endmodule : tb
